//--- hw/stm_pkg.sv
/*
 * constants and types shared by the status-transfer / multiply unit:
 * bus offsets, status word layout, mode codes, operation kinds, state.
 * assumes a single 32-bit ahb-lite master on the core clock.
 */
package stm_pkg;

	// bus offsets (byte addresses, one word each) and the addr[7:6] value of the 16-word register window
	localparam logic [7:0]  OFS_INSTR     = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_LIVE      = 8'h08;
	localparam logic [7:0]  OFS_SAVED     = 8'h0c;
	localparam logic [1:0]  GPR_WINDOW    = 2'h1;

	localparam int          GPR_COUNT     = 16;
	localparam int          SAVED_COUNT   = 5;
	localparam int          BOOTH_BITS    = 8;
	localparam logic [1:0]  BOOTH_LAST    = 2'h3;

	// status word layout
	localparam logic [31:0] PSR_IMPL_MASK = 32'hf00000ff;
	localparam logic [31:0] PSR_FLAG_MASK = 32'hf0000000;
	localparam int          FLAG_NEG      = 31;
	localparam int          FLAG_ZERO     = 30;
	localparam int          FLAG_CARRY    = 29;
	localparam int          FLAG_OVF      = 28;
	localparam logic [31:0] LIVE_RESET    = 32'h000000d3;
	localparam logic [31:0] WORD_RESET    = 32'h00000000;

	// mode_bits encodings
	localparam logic [4:0]  MODE_USER     = 5'h10;
	localparam logic [4:0]  MODE_FAST_IRQ = 5'h11;
	localparam logic [4:0]  MODE_IRQ      = 5'h12;
	localparam logic [4:0]  MODE_SUPER    = 5'h13;
	localparam logic [4:0]  MODE_ABORT    = 5'h17;
	localparam logic [4:0]  MODE_UNDEF    = 5'h1b;
	localparam logic [2:0]  SAVED_NONE    = 3'h7;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_STATUS_READ,
		OP_STATUS_WRITE_ALL,
		OP_STATUS_WRITE_FLAGS,
		OP_PRODUCT,
		OP_PRODUCT_ADD
	} op_kind_type;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ahb_req_type;

	typedef struct packed {
		logic [GPR_COUNT-1:0][31:0]   regs;
		logic [31:0]                  live;
		logic [SAVED_COUNT-1:0][31:0] saved;
		logic                         busy;
		logic [1:0]                   iter;
		logic [31:0]                  mcand;
		logic [31:0]                  mplier;
		logic                         prevBit;
		logic [31:0]                  acc;
		logic [3:0]                   mulDest;
		logic                         mulFlags;
		ahb_req_type                  pend;
		logic                         hreadyout;
		logic                         hresp;
		logic [31:0]                  hrdata;
		logic                         lastSkipped;
		op_kind_type                  lastOp;
	} state_type;

endpackage : stm_pkg

//--- hw/status_transfer_multiply.sv
/*
 * status word transfer and multiply execution unit with its register file,
 * live and saved status words, reached over an ahb-lite slave port.
 * assumes hready is this slave's own hreadyout and single word transfers.
 */
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps

//Function
//- act only when the condition field passes against current flags
//- decode status transfers from test/compare encodings with flag bit clear
//- status read copies whole live or current saved word to a register
//- whole status write loads live or saved word from a register
//- flags-only write copies source bits 31..28 into the four flags
//- user mode protects live control bits; privileged modes write all
//- saved word chosen by the mode in force at execution
//- only twelve status bits exist; the rest are reserved
//- multiplies use an 8-bit Booth step per iteration
//- product writes multiplicand times multiplier, addend ignored
//- only the low 32 product bits are returned
//- optional flags: negative from bit 31, zero test, overflow kept
module status_transfer_multiply
	import stm_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);

	state_type   s_q;
	state_type   s_d;
	logic        issue;
	op_kind_type opNow;
	logic        condNow;
	logic [2:0]  savedIdx;
	logic [31:0] savedCur;
	logic [31:0] srcWord;
	logic [31:0] stepAcc;
	logic [31:0] mulExpect;
	logic [3:0]  rdIdx;

	function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f); // f = n z c v
		logic r;
		unique case (c)
			4'h0: r = f[2];
			4'h1: r = !f[2];
			4'h2: r = f[1];
			4'h3: r = !f[1];
			4'h4: r = f[3];
			4'h5: r = !f[3];
			4'h6: r = f[0];
			4'h7: r = !f[0];
			4'h8: r = f[1] && !f[2];
			4'h9: r = !f[1] || f[2];
			4'ha: r = f[3] == f[0];
			4'hb: r = f[3] != f[0];
			4'hc: r = !f[2] && (f[3] == f[0]);
			4'hd: r = f[2] || (f[3] != f[0]);
			4'he: r = 1'b1;
			4'hf: r = 1'b0;
		endcase
		return r;
	endfunction : cond_ok

	// test/compare opcodes 10xx with the flag bit clear carry the status moves
	function automatic op_kind_type decode_op(input logic [31:0] w);
		op_kind_type k;
		k = OP_NONE;
		if (w[27:22] == 6'h00 && w[7:4] == 4'h9)
		begin
			k = w[21] ? OP_PRODUCT_ADD : OP_PRODUCT;
		end
		else if (w[27:26] == 2'h0 && w[24:23] == 2'h2 && !w[20])
		begin
			if (!w[21])
			begin
				if (!w[25] && w[19:16] == 4'hf && w[11:0] == 12'h000)
					k = OP_STATUS_READ;
			end
			else if (w[15:12] == 4'hf)
			begin
				if (w[19:16] == 4'h9 && !w[25] && w[11:4] == 8'h00)
					k = OP_STATUS_WRITE_ALL;
				else if (w[19:16] == 4'h8)
					k = OP_STATUS_WRITE_FLAGS;
			end
		end
		return k;
	endfunction : decode_op

	function automatic logic [2:0] saved_index(input logic [4:0] m);
		logic [2:0] i;
		unique case (m)
			MODE_FAST_IRQ: i = 3'h0;
			MODE_IRQ:      i = 3'h1;
			MODE_SUPER:    i = 3'h2;
			MODE_ABORT:    i = 3'h3;
			MODE_UNDEF:    i = 3'h4;
			default:       i = SAVED_NONE;
		endcase
		return i;
	endfunction : saved_index

	// four radix-4 digits cover eight multiplier bits per call
	function automatic logic [31:0] booth_step(input logic [31:0] acc,
			input logic [31:0] mc, input logic [8:0] bits);
		logic [31:0] sum;
		logic [2:0]  g;
		sum = acc;
		for (int j = 0; j < 4; j++)
		begin
			g = bits[2*j +: 3];
			unique case (g)
				3'h1, 3'h2: sum = sum + (mc << (2*j));
				3'h3:       sum = sum + (mc << (2*j+1));
				3'h4:       sum = sum - (mc << (2*j+1));
				3'h5, 3'h6: sum = sum - (mc << (2*j));
				default:    sum = sum;
			endcase
		end
		return sum;
	endfunction : booth_step

	always_comb
	begin
		s_d       = s_q;
		issue     = 1'b0;
		opNow     = decode_op(hwdata);
		condNow   = cond_ok(hwdata[31:28], s_q.live[31:28]);
		rdIdx     = hwdata[15:12];
		savedIdx  = saved_index(s_q.live[4:0]);
		savedCur  = (savedIdx == SAVED_NONE) ? WORD_RESET : s_q.saved[savedIdx];
		srcWord   = s_q.regs[hwdata[3:0]];
		if (hwdata[25])
			srcWord = {24'h000000, hwdata[7:0]} >> {hwdata[11:8], 1'b0}
				| {24'h000000, hwdata[7:0]} << (6'h20 - {1'b0, hwdata[11:8], 1'b0});
		mulExpect = 32'(s_q.regs[hwdata[3:0]] * s_q.regs[hwdata[11:8]])
			+ (hwdata[21] ? s_q.regs[hwdata[15:12]] : WORD_RESET);
		stepAcc   = booth_step(s_q.acc, s_q.mcand, {s_q.mplier[7:0], s_q.prevBit});

		// data phase: one wait state, longer while a multiply runs
		if (s_q.pend.valid && !s_q.busy)
		begin
			if (s_q.pend.write)
			begin
				if (s_q.pend.addr == OFS_INSTR)
					issue = 1'b1;
				else if (s_q.pend.addr == OFS_LIVE)
					s_d.live = hwdata & PSR_IMPL_MASK;
				else if (s_q.pend.addr == OFS_SAVED && savedIdx != SAVED_NONE)
					s_d.saved[savedIdx] = hwdata & PSR_IMPL_MASK;
				else if (s_q.pend.addr[7:6] == GPR_WINDOW)
					s_d.regs[s_q.pend.addr[5:2]] = hwdata;
			end
			else
			begin
				if (s_q.pend.addr == OFS_INSTR)
					s_d.hrdata = WORD_RESET;
				else if (s_q.pend.addr == OFS_STATUS)
					s_d.hrdata = {27'h0, s_q.lastOp, s_q.lastSkipped, s_q.busy};
				else if (s_q.pend.addr == OFS_LIVE)
					s_d.hrdata = s_q.live & PSR_IMPL_MASK;
				else if (s_q.pend.addr == OFS_SAVED)
					s_d.hrdata = savedCur;
				else if (s_q.pend.addr[7:6] == GPR_WINDOW)
					s_d.hrdata = s_q.regs[s_q.pend.addr[5:2]];
				else
					s_d.hrdata = WORD_RESET;
			end
			s_d.pend.valid = 1'b0;
			s_d.hreadyout  = 1'b1;
		end

		if (issue)
		begin
			s_d.lastOp      = opNow;
			s_d.lastSkipped = !condNow;
			if (condNow)
			begin
				unique case (opNow)
					OP_STATUS_READ:
						s_d.regs[rdIdx] = hwdata[22] ? savedCur
							: (s_q.live & PSR_IMPL_MASK);
					OP_STATUS_WRITE_ALL, OP_STATUS_WRITE_FLAGS:
					begin
						if (hwdata[22])
						begin
							// no saved word exists in user mode
							if (savedIdx != SAVED_NONE)
							begin
								if (opNow == OP_STATUS_WRITE_ALL)
									s_d.saved[savedIdx] = srcWord & PSR_IMPL_MASK;
								else
									s_d.saved[savedIdx] = (savedCur & ~PSR_FLAG_MASK)
										| (srcWord & PSR_FLAG_MASK);
							end
						end
						else if (opNow == OP_STATUS_WRITE_ALL
								&& s_q.live[4:0] != MODE_USER)
							s_d.live = srcWord & PSR_IMPL_MASK;
						else
							s_d.live = (s_q.live & ~PSR_FLAG_MASK)
								| (srcWord & PSR_FLAG_MASK);
					end
					OP_PRODUCT, OP_PRODUCT_ADD:
					begin
						s_d.busy     = 1'b1;
						s_d.iter     = 2'h0;
						s_d.mcand    = s_q.regs[hwdata[3:0]];
						s_d.mplier   = s_q.regs[hwdata[11:8]];
						s_d.prevBit  = 1'b0;
						s_d.acc      = (opNow == OP_PRODUCT_ADD)
							? s_q.regs[hwdata[15:12]] : WORD_RESET;
						s_d.mulDest  = hwdata[19:16];
						s_d.mulFlags = hwdata[20];
					end
					default:
						s_d.lastOp = OP_NONE;
				endcase
			end
		end

		// operands were latched at issue, so dest may alias any source
		if (s_q.busy)
		begin
			s_d.acc     = stepAcc;
			s_d.prevBit = s_q.mplier[BOOTH_BITS-1];
			s_d.mplier  = s_q.mplier >> BOOTH_BITS;
			s_d.mcand   = s_q.mcand << BOOTH_BITS;
			s_d.iter    = s_q.iter + 2'h1;
			if (s_q.iter == BOOTH_LAST)
			begin
				s_d.busy             = 1'b0;
				s_d.regs[s_q.mulDest] = stepAcc;
				if (s_q.mulFlags)
				begin
					// carry is left as it was; its value is meaningless here
					s_d.live[FLAG_NEG]  = stepAcc[31];
					s_d.live[FLAG_ZERO] = (stepAcc == WORD_RESET);
				end
			end
		end

		// address phase
		if (hsel && htrans[1] && hready)
		begin
			s_d.pend.valid = 1'b1;
			s_d.pend.write = hwrite;
			s_d.pend.addr  = haddr[7:0];
			s_d.hreadyout  = 1'b0;
		end
		s_d.hresp = 1'b0;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q           <= '0;
			s_q.live      <= LIVE_RESET;
			s_q.hreadyout <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign hrdata    = s_q.hrdata;
	assign hreadyout = s_q.hreadyout;
	assign hresp     = s_q.hresp;

	// helper: reference result captured at issue
	logic [31:0] expect_q;
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			expect_q <= '0;
		else if (issue)
			expect_q <= mulExpect;
	end

	property p_mul_length;
		@(posedge core_clk) disable iff (!reset_n)
		$rose(s_q.busy) |-> s_q.busy [*4] ##1 !s_q.busy;
	endproperty
	a_mul_length: assert property (p_mul_length)
		else $error("multiply did not take four steps");

	property p_stall;
		@(posedge core_clk) disable iff (!reset_n)
		(s_q.pend.valid && s_q.busy) |=> !s_q.hreadyout;
	endproperty
	a_stall: assert property (p_stall)
		else $error("bus access completed during multiply");

	property p_mul_result;
		@(posedge core_clk) disable iff (!reset_n)
		$fell(s_q.busy) |-> s_q.regs[$past(s_q.mulDest)] == expect_q;
	endproperty
	a_mul_result: assert property (p_mul_result)
		else $error("multiply result wrong");

	property p_mul_flags;
		@(posedge core_clk) disable iff (!reset_n)
		($fell(s_q.busy) && s_q.mulFlags) |->
			s_q.live[FLAG_NEG] == expect_q[31]
			&& s_q.live[FLAG_ZERO] == (expect_q == WORD_RESET)
			&& s_q.live[FLAG_OVF] == $past(s_q.live[FLAG_OVF]);
	endproperty
	a_mul_flags: assert property (p_mul_flags)
		else $error("multiply flags wrong");

	property p_user_protect;
		@(posedge core_clk) disable iff (!reset_n)
		(issue && s_q.live[4:0] == MODE_USER && !hwdata[22]
			&& (opNow == OP_STATUS_WRITE_ALL || opNow == OP_STATUS_WRITE_FLAGS))
			|=> s_q.live[27:0] == $past(s_q.live[27:0]);
	endproperty
	a_user_protect: assert property (p_user_protect)
		else $error("user mode changed control bits");

	property p_cond_fail;
		@(posedge core_clk) disable iff (!reset_n)
		(issue && !condNow) |=> s_q.live == $past(s_q.live) && !s_q.busy
			&& s_q.regs == $past(s_q.regs) && s_q.lastSkipped;
	endproperty
	a_cond_fail: assert property (p_cond_fail)
		else $error("failed condition still had effect");

	property p_reserved;
		@(posedge core_clk) disable iff (!reset_n)
		(s_q.live & ~PSR_IMPL_MASK) == WORD_RESET;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bit set");

	property p_status_read;
		@(posedge core_clk) disable iff (!reset_n)
		(issue && opNow == OP_STATUS_READ && condNow && !hwdata[22])
			|=> s_q.regs[$past(rdIdx)] == $past(s_q.live);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read copied wrong word");

	property p_flag_write;
		@(posedge core_clk) disable iff (!reset_n)
		(issue && opNow == OP_STATUS_WRITE_FLAGS && condNow && !hwdata[22])
			|=> s_q.live[31:28] == $past(srcWord[31:28])
			&& s_q.live[27:0] == $past(s_q.live[27:0]);
	endproperty
	a_flag_write: assert property (p_flag_write)
		else $error("flags-only write wrong");

endmodule : status_transfer_multiply

//--- test/status_transfer_multiply_test.sv
/*
 * self-checking bench for the status transfer and multiply unit:
 * bus tasks, then instruction sequences checked through the register map.
 * assumes hready is looped back from hreadyout and a 25 MHz core clock.
 */
`timescale 1ns/1ps

module status_transfer_multiply_test
	import stm_pkg::*;
;
	logic        core_clk;
	logic        reset_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	int          mismatches;
	int          cmp_count;

	status_transfer_multiply i_dut (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp)
	);

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		cmp_count++;
		if (seen !== expected)
		begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask : check

	// level settled at the falling edge is what the next rising edge samples
	task automatic wait_ready();
		int n;
		n = 0;
		@(negedge core_clk);
		while (hreadyout !== 1'b1)
		begin
			n++;
			if (n > 100)
			begin
				mismatches++;
				end_of_test();
			end
			@(negedge core_clk);
		end
	endtask : wait_ready

	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		haddr  <= {24'h0, addr};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_ready();
		@(posedge core_clk);
		htrans <= 2'h0;
		hwdata <= wdata;
		wait_ready();
		rdata = hrdata;
		@(posedge core_clk);
	endtask : xfer

	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		logic [31:0] d;
		xfer(1'b1, addr, data, d);
	endtask : wr

	task automatic rd(input logic [7:0] addr, input logic [31:0] expected);
		logic [31:0] d;
		xfer(1'b0, addr, 32'h0, d);
		check(d, expected);
		check({31'h0, hresp}, 32'h0);
	endtask : rd

	task automatic ins(input logic [31:0] w);
		wr(OFS_INSTR, w);
	endtask : ins

	function automatic logic [7:0] ra(input logic [3:0] n);
		return 8'h40 + {2'h0, n, 2'h0};
	endfunction : ra

	function automatic logic [31:0] mulw(input logic [3:0] c, input logic a, input logic s,
		input logic [3:0] d, input logic [3:0] n, input logic [3:0] ms, input logic [3:0] mc);
		return {c, 6'h0, a, s, d, n, ms, 4'h9, mc};
	endfunction : mulw

	function automatic logic [31:0] status_read_op(input logic [3:0] c, input logic p, input logic [3:0] d);
		return {c, 5'h02, p, 2'h0, 4'hf, d, 12'h0};
	endfunction : status_read_op

	// f selects whole word (9) or flags only (8)
	function automatic logic [31:0] msrw(input logic [3:0] c, input logic imm, input logic p,
		input logic [3:0] f, input logic [11:0] op);
		return {c, 2'h0, imm, 2'h2, p, 2'h2, f, 4'hf, op};
	endfunction : msrw

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial
	begin
		mismatches = 0;
		cmp_count  = 0;
		reset_n    = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = 3'h2;
		hwdata     = 32'h0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		hsel    <= 1'b1;
		rd(OFS_LIVE, 32'h000000d3);
		rd(ra(4'h4), 32'h0);
		wr(ra(4'h1), 32'hfffffff6);
		wr(ra(4'h2), 32'h00000014);
		wr(ra(4'h3), 32'h00000005);
		// addend field nonzero on a plain product must be ignored
		ins(mulw(4'he, 1'b0, 1'b1, 4'h4, 4'h3, 4'h2, 4'h1));
		rd(ra(4'h4), 32'hffffff38);
		rd(OFS_LIVE, 32'h800000d3);
		rd(OFS_STATUS, 32'h00000010);
		ins(mulw(4'he, 1'b1, 1'b0, 4'h5, 4'h3, 4'h2, 4'h1));
		rd(ra(4'h5), 32'hffffff3d);
		rd(OFS_LIVE, 32'h800000d3);
		// immediate 0x01 rotated right by 4 gives overflow only
		ins(msrw(4'he, 1'b1, 1'b0, 4'h8, 12'h201));
		rd(OFS_LIVE, 32'h100000d3);
		ins(mulw(4'he, 1'b0, 1'b1, 4'h6, 4'h0, 4'h1, 4'h7));
		rd(OFS_LIVE, 32'h500000d3);
		ins(status_read_op(4'h1, 1'b0, 4'h8));
		rd(ra(4'h8), 32'h0);
		ins(status_read_op(4'h0, 1'b0, 4'h8));
		rd(ra(4'h8), 32'h500000d3);
		rd(OFS_STATUS, 32'h00000004);
		// same encoding with the flag update bit set is no transfer
		ins(32'he11f8000);
		rd(OFS_STATUS, 32'h0);
		wr(ra(4'h9), 32'h2ff000d1);
		ins(msrw(4'he, 1'b0, 1'b0, 4'h9, 12'h009));
		rd(OFS_LIVE, 32'h200000d1);
		wr(ra(4'ha), 32'ha00000d3);
		ins(msrw(4'he, 1'b0, 1'b1, 4'h9, 12'h00a));
		rd(OFS_SAVED, 32'ha00000d3);
		ins(status_read_op(4'he, 1'b1, 4'hb));
		rd(ra(4'hb), 32'ha00000d3);
		wr(OFS_LIVE, 32'h000000d2);
		rd(OFS_SAVED, 32'h0);
		ins(msrw(4'he, 1'b0, 1'b1, 4'h8, 12'h009));
		rd(OFS_SAVED, 32'h20000000);
		wr(OFS_LIVE, 32'h000000d1);
		rd(OFS_SAVED, 32'ha00000d3);
		wr(OFS_LIVE, 32'h00000010);
		wr(ra(4'hc), 32'hf00000d3);
		ins(msrw(4'he, 1'b0, 1'b0, 4'h9, 12'h00c));
		rd(OFS_LIVE, 32'hf0000010);
		// user mode has no saved word: bus write dropped, read gives zero
		wr(OFS_SAVED, 32'hf00000d3);
		rd(OFS_SAVED, 32'h0);
		rd(8'h20, 32'h0);
		end_of_test();
	end

endmodule : status_transfer_multiply_test
